// ---- hw/tio_pkg.sv ----
/*
 * tio_pkg: constants and carrier types for the timer pin-function block.
 * Assumes a single 25 MHz peripheral clock and an 8-bit APB byte address.
 */
package tio_pkg;

   // sizes
   localparam int          TIO_SLOTS   = 8;     // general registers A..D ch0, A/B ch1, A/B ch2
   localparam int          TIO_CHANS   = 3;     // counter channels
   localparam int          TIO_CNT_W   = 16;    // counter and general register width
   localparam int          TIO_ADDR_W  = 8;     // apb byte address width

   // register byte offsets
   localparam logic [7:0]  OFF_CTRL0H  = 8'h00; // pin_function_ctrl ch0 high (A, B)
   localparam logic [7:0]  OFF_CTRL0L  = 8'h04; // pin_function_ctrl ch0 low (C, D)
   localparam logic [7:0]  OFF_CTRL1   = 8'h08; // pin_function_ctrl ch1
   localparam logic [7:0]  OFF_CTRL2   = 8'h0C; // pin_function_ctrl ch2
   localparam logic [7:0]  OFF_MODE0   = 8'h10; // channel_mode_reg ch0
   localparam logic [7:0]  OFF_MODE1   = 8'h14; // channel_mode_reg ch1
   localparam logic [7:0]  OFF_MODE2   = 8'h18; // channel_mode_reg ch2
   localparam logic [7:0]  OFF_START   = 8'h1C; // counter_start_reg
   localparam logic [7:0]  OFF_STATUS  = 8'h20; // sticky events, read clears
   localparam logic [7:0]  OFF_MASK    = 8'h24; // interrupt mask
   localparam logic [2:0]  GR_PAGE     = 3'h2;  // general regs at 0x40 + 4*slot

   // reset values
   localparam logic [7:0]  RST_CTRL    = 8'h00;
   localparam logic [7:0]  RST_MODE    = 8'hC0;
   localparam logic [7:0]  MODE_FIXED  = 8'hC0; // bits 7,6 read one
   localparam logic [7:0]  MODE_WM_CH0 = 8'h3F; // ch0 has buffer bits
   localparam logic [7:0]  MODE_WM_CHN = 8'h0F; // ch1/2 buffer bits read zero

   // field positions
   localparam int          BFB_BIT     = 5;     // buffer_pair_b_en
   localparam int          BFA_BIT     = 4;     // buffer pair a enable
   localparam logic [3:0]  MD_PWM2     = 4'h3;  // second pwm mode
   localparam int          FN_CAP_BIT  = 3;     // field: 1 = input capture
   localparam int          FN_INIT_BIT = 2;     // field: initial level / prohibited
   localparam logic [1:0]  ACT_OFF     = 2'h0;  // output disabled
   localparam logic [1:0]  ACT_ZERO    = 2'h1;  // drive 0 at match
   localparam logic [1:0]  ACT_ONE     = 2'h2;  // drive 1 at match
   localparam logic [1:0]  ACT_TOGGLE  = 2'h3;  // toggle at match

   // apb request from the master
   typedef struct packed {
      logic                  psel;
      logic                  penable;
      logic                  pwrite;
      logic [TIO_ADDR_W-1:0] paddr;
      logic [31:0]           pwdata;
   } tio_apb_req_t;

   // apb answer to the master
   typedef struct packed {
      logic [31:0]           prdata;
      logic                  pready;
      logic                  pslverr;
   } tio_apb_rsp_t;

endpackage

// ---- hw/tio_timer_io_control.sv ----
/*
 * tio_timer_io_control: pin-function control of a three-channel 16-bit timer.
 * Holds the function-select, mode, start, general, status and mask registers,
 * turns compare matches into pin levels and pin edges into captures.
 * Assumes counters live outside and deliver their count and a clear pulse,
 * and that all inputs are synchronous to clk.
 */
// Notes on behaviour
// - function registers eight bits, reset zero
// - four function registers: two ch0, one each
// - buffered C/D ignore field, act as buffer
// - initial level driven while counter stopped
// - pwm mode two: initial level at clear
// - bits 7..4 select B, or D
// - codes 0000, 0100 compare, pin disabled
// - codes 0001..0011 init 0, then 0/1/toggle
// - codes 0101..0111 init 1, then 0/1/toggle
// - 1000 rising capture, 1001 falling capture
// - 1010, 1011 capture on both edges
// - each capture register uses its own pin
// - buffer-B set: no events for D
// - bits 3..0 select A, or C
// - buffer-B bit pairs B with D
`timescale 1ns/1ps
`default_nettype none

module tio_timer_io_control (
   input  wire logic                   clk,          // 25 MHz peripheral clock
   input  wire logic                   arst_n,       // async reset, active low
   input  wire logic                   ce,           // freezes all state when low
   input  wire tio_pkg::tio_apb_req_t  apb_req,      // apb request
   output var   tio_pkg::tio_apb_rsp_t apb_rsp,      // apb answer
   input  wire logic [2:0][15:0]       ch_count,     // channel counters
   input  wire logic [2:0]             ch_clear,     // counter cleared to zero, pulse
   input  wire logic [7:0]             pin_in,       // capture pin levels, per slot
   output logic [7:0]                  pin_out,      // compare pin levels, per slot
   output logic [7:0]                  pin_oe_n,     // pin drive enable, low drives
   output logic [2:0]                  counter_run,  // counter_run_bit per channel
   output logic                        irq           // level interrupt
);

   // all state of the block
   typedef struct packed {
      logic [3:0][7:0]       ctrl;        // pin_function_ctrl 0h, 0l, 1, 2
      logic [2:0][7:0]       mode;        // channel_mode_reg per channel
      logic [2:0]            run;         // counter_start_reg
      logic [7:0][15:0]      gr;          // general registers per slot
      logic [7:0]            pin_prev;    // last pin sample, edge detect
      logic [7:0]            match_prev;  // last match, one event per match
      logic [7:0]            pin_out;     // compare output levels
      logic [7:0]            pin_oe_n;    // drive enables
      logic [7:0]            status;      // sticky events
      logic [7:0]            mask;        // interrupt enables
      logic                  irq;         // registered interrupt
      tio_pkg::tio_apb_rsp_t rsp;         // registered apb answer
   } tio_state_t;

   tio_state_t  s_q;                      // current state
   tio_state_t  s_d;                      // next state

   // per-slot decode
   logic [7:0][3:0]  fsel;                // function field of each slot
   logic [7:0]       buf_off;             // slot serves only as buffer
   logic [7:0]       is_cmp;              // output compare function
   logic [7:0]       drive_en;            // compare with pin enabled
   logic [7:0]       cap_evt;             // capture event this cycle
   logic [7:0]       match;               // count equals register
   logic [7:0]       cmp_evt;             // first cycle of a match
   logic [7:0][15:0] slot_cnt;            // count of slot's channel
   logic [7:0]       slot_run;            // slot's counter running
   logic [7:0]       slot_clr;            // pwm2 clear of slot's channel

   // apb phase decode
   logic             setup;               // setup cycle
   logic             acc_wr;              // completing write
   logic             acc_rd;              // completing read
   logic [7:0]       wbyte;               // low write byte

   assign setup  = apb_req.psel && !apb_req.penable;
   assign acc_wr = apb_req.psel && apb_req.penable && s_q.rsp.pready && apb_req.pwrite;
   assign acc_rd = apb_req.psel && apb_req.penable && s_q.rsp.pready && !apb_req.pwrite;
   assign wbyte  = apb_req.pwdata[7:0];

   // slot i: ch0 A,B,C,D = 0..3, ch1 A,B = 4,5, ch2 A,B = 6,7
   for (genvar i = 0; i < 8; i++) begin : g_slot
      localparam int CH = (i < 4) ? 0 : (i - 2) / 2;
      logic rise;                         // rising edge on own pin
      logic fall;                         // falling edge on own pin
      // low nibble for A/C, high nibble for B/D
      assign fsel[i] = s_q.ctrl[i/2][(i%2)*4 +: 4];
      // buffered C or D loses its function
      assign buf_off[i] = (i == 2 && s_q.mode[0][tio_pkg::BFA_BIT])
                       || (i == 3 && s_q.mode[0][tio_pkg::BFB_BIT]);
      assign is_cmp[i]   = !fsel[i][tio_pkg::FN_CAP_BIT] && !buf_off[i];
      // action code 00 keeps the pin undriven
      assign drive_en[i] = is_cmp[i] && (fsel[i][1:0] != tio_pkg::ACT_OFF);
      // each slot watches its own pin only
      assign rise = pin_in[i] && !s_q.pin_prev[i];
      assign fall = !pin_in[i] && s_q.pin_prev[i];
      // 1000 rise, 1001 fall, 101x both; 11xx does nothing
      assign cap_evt[i] = fsel[i][tio_pkg::FN_CAP_BIT] && !fsel[i][tio_pkg::FN_INIT_BIT]
                       && !buf_off[i]
                       && (fsel[i][1] ? (rise || fall) : (fsel[i][0] ? fall : rise));
      assign slot_cnt[i] = ch_count[CH];
      assign slot_run[i] = s_q.run[CH];
      assign slot_clr[i] = ch_clear[CH] && (s_q.mode[CH][3:0] == tio_pkg::MD_PWM2);
      assign match[i]    = s_q.run[CH] && (ch_count[CH] == s_q.gr[i]);
      // one event per match, even if the count stalls on the value
      assign cmp_evt[i]  = is_cmp[i] && match[i] && !s_q.match_prev[i];
   end

   // next-state logic
   always_comb begin
      s_d = s_q;
      // answer every setup with no wait state
      s_d.rsp.pready = setup;
      if (setup) begin
         s_d.rsp.pslverr = 1'b0;
         s_d.rsp.prdata  = 32'h0000_0000;
         if (apb_req.paddr[7:5] == tio_pkg::GR_PAGE) begin
            s_d.rsp.prdata = {16'h0000, s_q.gr[apb_req.paddr[4:2]]};
         end else begin
            case (apb_req.paddr)
               tio_pkg::OFF_CTRL0H: s_d.rsp.prdata = {24'h00_0000, s_q.ctrl[0]};
               tio_pkg::OFF_CTRL0L: s_d.rsp.prdata = {24'h00_0000, s_q.ctrl[1]};
               tio_pkg::OFF_CTRL1:  s_d.rsp.prdata = {24'h00_0000, s_q.ctrl[2]};
               tio_pkg::OFF_CTRL2:  s_d.rsp.prdata = {24'h00_0000, s_q.ctrl[3]};
               tio_pkg::OFF_MODE0:  s_d.rsp.prdata = {24'h00_0000, s_q.mode[0]};
               tio_pkg::OFF_MODE1:  s_d.rsp.prdata = {24'h00_0000, s_q.mode[1]};
               tio_pkg::OFF_MODE2:  s_d.rsp.prdata = {24'h00_0000, s_q.mode[2]};
               tio_pkg::OFF_START:  s_d.rsp.prdata = {29'h0000_0000, s_q.run};
               tio_pkg::OFF_STATUS: s_d.rsp.prdata = {24'h00_0000, s_q.status};
               tio_pkg::OFF_MASK:   s_d.rsp.prdata = {24'h00_0000, s_q.mask};
               // unmapped: zero data and an error
               default:             s_d.rsp.pslverr = 1'b1;
            endcase
         end
      end

      // register writes take effect at the completing edge
      if (acc_wr) begin
         if (apb_req.paddr[7:5] == tio_pkg::GR_PAGE) begin
            s_d.gr[apb_req.paddr[4:2]] = apb_req.pwdata[15:0];
         end else begin
            case (apb_req.paddr)
               // full eight-bit read/write
               tio_pkg::OFF_CTRL0H: s_d.ctrl[0] = wbyte;
               tio_pkg::OFF_CTRL0L: s_d.ctrl[1] = wbyte;
               tio_pkg::OFF_CTRL1:  s_d.ctrl[2] = wbyte;
               tio_pkg::OFF_CTRL2:  s_d.ctrl[3] = wbyte;
               // reserved mode bits keep their fixed values
               tio_pkg::OFF_MODE0:
                  s_d.mode[0] = (wbyte & tio_pkg::MODE_WM_CH0) | tio_pkg::MODE_FIXED;
               tio_pkg::OFF_MODE1:
                  s_d.mode[1] = (wbyte & tio_pkg::MODE_WM_CHN) | tio_pkg::MODE_FIXED;
               tio_pkg::OFF_MODE2:
                  s_d.mode[2] = (wbyte & tio_pkg::MODE_WM_CHN) | tio_pkg::MODE_FIXED;
               tio_pkg::OFF_START:  s_d.run  = wbyte[2:0];
               tio_pkg::OFF_MASK:   s_d.mask = wbyte;
               default: ;           // status and unmapped ignore writes
            endcase
         end
      end

      // read clears only the bits it reported: an event that lands after the
      // setup cycle would otherwise vanish unseen; events below still set
      if (acc_rd && apb_req.paddr == tio_pkg::OFF_STATUS) begin
         s_d.status = s_q.status & ~s_q.rsp.prdata[7:0];
      end

      // per-slot pin and register behaviour; hardware wins over a write
      for (int i = 0; i < 8; i++) begin
         s_d.pin_prev[i]   = pin_in[i];
         s_d.match_prev[i] = match[i];
         if (cap_evt[i]) begin
            // latch the channel count
            s_d.gr[i] = slot_cnt[i];
            // old value moves to the buffer partner
            if (i < 2 && buf_off[(i + 2) % 8]) begin
               s_d.gr[(i + 2) % 8] = s_q.gr[i];
            end
         end
         if (cmp_evt[i]) begin
            case (fsel[i][1:0])
               tio_pkg::ACT_ZERO:   s_d.pin_out[i] = 1'b0;
               tio_pkg::ACT_ONE:    s_d.pin_out[i] = 1'b1;
               tio_pkg::ACT_TOGGLE: s_d.pin_out[i] = !s_q.pin_out[i];
               default: ;           // disabled: level unused
            endcase
            // buffer reloads the compare value after a match
            if (i < 2 && buf_off[(i + 2) % 8]) begin
               s_d.gr[i] = s_q.gr[(i + 2) % 8];
            end
         end
         if (!slot_run[i]) begin
            // stopped counter shows the initial level
            s_d.pin_out[i] = fsel[i][tio_pkg::FN_INIT_BIT];
         end else if (slot_clr[i]) begin
            // pwm2: initial level re-applied at clear, beats a match
            s_d.pin_out[i] = fsel[i][tio_pkg::FN_INIT_BIT];
         end
         s_d.pin_oe_n[i] = !drive_en[i];
         // set wins over a same-cycle read clear
         if (cap_evt[i] || cmp_evt[i]) begin
            s_d.status[i] = 1'b1;
         end
      end
      s_d.irq = |(s_d.status & s_d.mask);
   end

   // state register, frozen while ce is low
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q            <= '0;
         s_q.ctrl       <= {4{tio_pkg::RST_CTRL}};
         s_q.mode       <= {3{tio_pkg::RST_MODE}};
         s_q.pin_oe_n   <= 8'hFF;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state flops
   assign apb_rsp     = s_q.rsp;
   assign pin_out     = s_q.pin_out;
   assign pin_oe_n    = s_q.pin_oe_n;
   assign counter_run = s_q.run;
   assign irq         = s_q.irq;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // write to ch0 high lands in full
   property p_ctrl_write;
      ce && acc_wr && apb_req.paddr == tio_pkg::OFF_CTRL0H
         |=> s_q.ctrl[0] == $past(apb_req.pwdata[7:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write lost");

   // stopped counter drives the initial level
   property p_init_level;
      ce && !s_q.run[0] |=> pin_out[0] == $past(fsel[0][2]);
   endproperty
   a_init_level: assert property (p_init_level) else $error("init level wrong");

   // pwm2 clear restores initial level
   property p_pwm2_clear;
      ce && s_q.run[0] && slot_clr[0] |=> pin_out[0] == $past(fsel[0][2]);
   endproperty
   a_pwm2_clear: assert property (p_pwm2_clear) else $error("pwm2 clear level");

   // code 0001 match drives zero
   property p_match_zero;
      ce && cmp_evt[1] && fsel[1] == 4'h1 && !slot_clr[1] |=> pin_out[1] == 1'b0;
   endproperty
   a_match_zero: assert property (p_match_zero) else $error("match zero wrong");

   // code 0111 match toggles
   property p_match_toggle;
      ce && cmp_evt[1] && fsel[1] == 4'h7 && !slot_clr[1]
         |=> pin_out[1] != $past(pin_out[1]);
   endproperty
   a_match_toggle: assert property (p_match_toggle) else $error("toggle failed");

   // disabled codes leave pin undriven
   property p_pin_off;
      ce && (fsel[4] == 4'h0 || fsel[4] == 4'h4) |=> pin_oe_n[4];
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("disabled pin driven");

   // rising capture copies the count and flags it
   property p_capture;
      ce && fsel[1] == 4'h8 && pin_in[1] && !s_q.pin_prev[1]
         |=> s_q.gr[1] == $past(ch_count[0]) && s_q.status[1];
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed");

   // both-edge capture fires on a fall
   property p_both_edges;
      ce && fsel[1][3:1] == 3'b101 && !pin_in[1] && s_q.pin_prev[1]
         |=> s_q.gr[1] == $past(ch_count[0]) && s_q.status[1];
   endproperty
   a_both_edges: assert property (p_both_edges) else $error("fall not captured");

   // buffered D never raises events
   property p_buf_quiet;
      ce && s_q.mode[0][tio_pkg::BFB_BIT] && !s_q.status[3] |=> !s_q.status[3];
   endproperty
   a_buf_quiet: assert property (p_buf_quiet) else $error("buffer D raised event");

   // ch0 low register is a second function register
   property p_ctrl_lo_wr;
      ce && acc_wr && apb_req.paddr == tio_pkg::OFF_CTRL0L
         |=> s_q.ctrl[1] == $past(apb_req.pwdata[7:0]);
   endproperty
   a_ctrl_lo_wr: assert property (p_ctrl_lo_wr) else $error("ctrl low write lost");

   // start write reaches the run outputs
   property p_run_out;
      ce && acc_wr && apb_req.paddr == tio_pkg::OFF_START
         |=> counter_run == $past(apb_req.pwdata[2:0]);
   endproperty
   a_run_out: assert property (p_run_out) else $error("run bits lost");

   // code 0010 match drives one
   property p_match_one;
      ce && cmp_evt[1] && fsel[1] == 4'h2 && !slot_clr[1] |=> pin_out[1];
   endproperty
   a_match_one: assert property (p_match_one) else $error("match one wrong");

   // code 0101 match drives zero from a high start
   property p_match_low;
      ce && cmp_evt[1] && fsel[1] == 4'h5 && !slot_clr[1] |=> !pin_out[1];
   endproperty
   a_match_low: assert property (p_match_low) else $error("match low wrong");

   // code 0110 match drives one
   property p_match_high;
      ce && cmp_evt[1] && fsel[1] == 4'h6 && !slot_clr[1] |=> pin_out[1];
   endproperty
   a_match_high: assert property (p_match_high) else $error("match high wrong");

   // compare codes with an action drive the pin
   property p_pin_on;
      ce && !fsel[1][3] && fsel[1][1:0] != tio_pkg::ACT_OFF |=> !pin_oe_n[1];
   endproperty
   a_pin_on: assert property (p_pin_on) else $error("enabled pin not driven");

   // capture codes never drive the pin
   property p_cap_undriven;
      ce && fsel[1][3] |=> pin_oe_n[1];
   endproperty
   a_cap_undriven: assert property (p_cap_undriven) else $error("capture pin driven");

   cover property (ce && cmp_evt[0] && fsel[0][1:0] == tio_pkg::ACT_TOGGLE);
   cover property (ce && cap_evt[3] && fsel[3] == 4'hA);
   cover property (ce && cap_evt[1] && s_q.mode[0][tio_pkg::BFB_BIT]);
   cover property (irq && acc_rd && apb_req.paddr == tio_pkg::OFF_STATUS);

endmodule

`default_nettype wire

// ---- dv/tio_pin_partner.sv ----
/*
 * tio_pin_partner: far side of the pin-function block: three channel
 * counters and the capture pin levels. Assumes one clock shared with the
 * block; the bench steers pins and counter loads through the tasks below.
 */
`timescale 1ns/1ps
`default_nettype none

module tio_pin_partner #(
   parameter int PERIOD = 16            // short wrap keeps match waits brief
) (
   input  wire logic        clk,         // peripheral clock
   input  wire logic        arst_n,      // async reset, active low
   input  wire logic [2:0]  counter_run, // run bit per channel
   output logic [2:0][15:0] ch_count,    // counter values
   output logic [2:0]       ch_clear,    // pulse when a counter wraps to zero
   output logic [7:0]       pin_in       // capture pin levels
);
   initial pin_in = 8'h00;               // external pins start low

   // counters run only while their run bit is set; stopped ones hold
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ch_count <= '0;
         ch_clear <= 3'h0;
      end else begin
         for (int c = 0; c < 3; c++) begin
            ch_clear[c] <= 1'b0;
            if (counter_run[c] && ch_count[c] == 16'(PERIOD - 1)) begin
               ch_count[c] <= 16'h0000;
               ch_clear[c] <= 1'b1;
            end else if (counter_run[c]) begin
               ch_count[c] <= ch_count[c] + 16'h0001;
            end
         end
      end
   end

   // load a stopped counter; only meaningful while its run bit is low
   task automatic set_count(input int c, input logic [15:0] v);
      @(posedge clk);
      ch_count[c] <= v;
   endtask

   // move one pin just after an edge, like a real source would
   task automatic set_pin(input int s, input logic v);
      @(posedge clk);
      pin_in[s] <= v;
   endtask
endmodule

`default_nettype wire

// ---- dv/tio_timer_io_control_tb.sv ----
/*
 * tio_timer_io_control_tb: register, compare, capture and interrupt checks
 * through the apb port. Assumes the partner model owns counters and pins.
 */
`timescale 1ns/1ps
`default_nettype none

module tio_timer_io_control_tb;
   logic                  clk = 1'b0;    // 25 MHz
   logic                  arst_n = 1'b0; // held low at start
   logic                  ce = 1'b1;     // clock enable
   tio_pkg::tio_apb_req_t apb_req = '0;  // apb master side
   tio_pkg::tio_apb_rsp_t apb_rsp;       // apb answer
   logic [2:0][15:0]      ch_count;      // from partner
   logic [2:0]            ch_clear;      // from partner
   logic [7:0]            pin_in;        // from partner
   logic [7:0]            pin_out;       // compare pins
   logic [7:0]            pin_oe_n;      // pin drive enables
   logic [2:0]            counter_run;   // run bits
   logic                  irq;           // level interrupt
   logic [31:0]           rd;            // last read data
   logic                  err;           // last slave error
   logic [7:0]            msk = 8'hFF;   // mirror of the mask register
   logic                  ini, aft;      // expected pin levels
   logic [1:0]            act;           // expected match action
   int                    failures = 0;
   int                    checked = 0;

   always #20 clk = ~clk;

   tio_timer_io_control i_tio_timer_io_control (
      .clk(clk), .arst_n(arst_n), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .ch_count(ch_count), .ch_clear(ch_clear), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .counter_run(counter_run), .irq(irq));

   tio_pin_partner i_tio_pin_partner (
      .clk(clk), .arst_n(arst_n), .counter_run(counter_run),
      .ch_count(ch_count), .ch_clear(ch_clear), .pin_in(pin_in));

   // verdict and end of run, reached from the main flow or a timeout
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      if (apb_rsp.pready !== 1'b1) begin
         failures++;
         tally_and_finish();
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask

   // bounded wait for channel 0 to show a count
   task automatic wait_cnt(input logic [15:0] v);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ch_count[0] !== v && n < 60);
      if (ch_count[0] !== v) begin
         failures++;
         tally_and_finish();
      end
   endtask

   // one pin edge on slot s with counter c loaded; hit says a capture is due
   task automatic cap(input int s, input int c, input logic lvl, input logic [15:0] v,
                      input logic hit);
      apb(1'b1, 8'h40 + 8'(4 * s), 32'h0);
      apb(1'b0, tio_pkg::OFF_STATUS, 32'h0);
      i_tio_pin_partner.set_count(c, v);
      i_tio_pin_partner.set_pin(s, lvl);
      repeat (3) @(posedge clk);
      chk(irq, hit & msk[s]);
      apb(1'b0, 8'h40 + 8'(4 * s), 32'h0);
      chk(rd, hit ? {16'h0, v} : 32'h0);
      apb(1'b0, tio_pkg::OFF_STATUS, 32'h0);
      chk(rd, hit ? (32'h1 << s) : 32'h0);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
   endtask

   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      chk(pin_oe_n, 8'hFF);
      // four control registers: reset zero, eight bits wide
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, 32'h0);
         apb(1'b1, 8'(4 * i), 32'hFFFF_FF5A);
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(rd, 32'h0000_005A);
         apb(1'b1, 8'(4 * i), 32'h0);
      end
      apb(1'b0, tio_pkg::OFF_MODE1, 32'h0);
      chk(rd, 32'h0000_00C0);
      apb(1'b0, 8'h30, 32'h0);
      chk({rd[30:0], err}, 32'h1); // unmapped place answers with an error
      apb(1'b1, tio_pkg::OFF_MASK, 32'hFF);
      // every compare code on general reg a (bits 3:0) then b (bits 7:4)
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 8; k++) begin
            ini = k[2];
            act = k[1:0];
            aft = (act == 2'h1) ? 1'b0 : (act == 2'h2) ? 1'b1 : ~ini;
            apb(1'b1, tio_pkg::OFF_CTRL0H, 32'(k) << (4 * s));
            apb(1'b1, 8'h40 + 8'(4 * s), 32'h3);
            repeat (2) @(posedge clk);
            chk(pin_oe_n[s], act == 2'h0);
            if (act != 2'h0)
               chk(pin_out[s], ini);
            apb(1'b1, tio_pkg::OFF_START, 32'h1);
            wait_cnt(16'h0003);
            repeat (3) @(posedge clk);
            if (act != 2'h0)
               chk(pin_out[s], aft);
            apb(1'b1, tio_pkg::OFF_START, 32'h0);
            repeat (2) @(posedge clk);
            if (act != 2'h0)
               chk(pin_out[s], ini);
         end
      end
      // second pwm mode: counter clear brings back the initial level
      apb(1'b1, tio_pkg::OFF_MODE0, 32'hC3);
      apb(1'b1, tio_pkg::OFF_CTRL0H, 32'h02);
      apb(1'b1, tio_pkg::OFF_START, 32'h1);
      wait_cnt(16'h0003);
      repeat (3) @(posedge clk);
      chk(pin_out[0], 1'b1);
      chk(counter_run, 32'h1);
      wait_cnt(16'h0000);
      repeat (2) @(posedge clk);
      chk(pin_out[0], 1'b0);
      apb(1'b1, tio_pkg::OFF_START, 32'h0);
      apb(1'b1, tio_pkg::OFF_MODE0, 32'hC0);
      // capture codes on ch0 b; 11xx is never written by software
      for (int k = 8; k < 12; k++) begin
         apb(1'b1, tio_pkg::OFF_CTRL0H, 32'(k) << 4);
         cap(1, 0, 1'b1, 16'h1100 + 16'(k), k != 9);
         cap(1, 0, 1'b0, 16'h2200 + 16'(k), k != 8);
      end
      // d paired as buffer with b: its field is ignored
      apb(1'b1, tio_pkg::OFF_MODE0, 32'hE0);
      apb(1'b1, tio_pkg::OFF_CTRL0L, 32'h80);
      cap(3, 0, 1'b1, 16'h3333, 1'b0);
      cap(3, 0, 1'b0, 16'h3434, 1'b0);
      // capture on b moves the old b value into d
      apb(1'b1, 8'h44, 32'h0ABC);
      i_tio_pin_partner.set_count(0, 16'h7777);
      i_tio_pin_partner.set_pin(1, 1'b1);
      repeat (3) @(posedge clk);
      apb(1'b0, 8'h4C, 32'h0);
      chk(rd, 32'h0000_0ABC);
      apb(1'b0, 8'h44, 32'h0);
      chk(rd, 32'h0000_7777);
      apb(1'b1, tio_pkg::OFF_MODE0, 32'hC0);
      cap(3, 0, 1'b1, 16'h4444, 1'b1);
      // ch1 b falling capture, with its interrupt masked off
      msk = 8'hDF;
      apb(1'b1, tio_pkg::OFF_MASK, 32'hDF);
      apb(1'b1, tio_pkg::OFF_CTRL1, 32'h90);
      cap(5, 1, 1'b1, 16'h5555, 1'b0);
      cap(5, 1, 1'b0, 16'h6666, 1'b1);
      // ce low freezes the block: the edge is taken only once ce returns
      msk = 8'hFF;
      apb(1'b1, tio_pkg::OFF_MASK, 32'hFF);
      apb(1'b1, tio_pkg::OFF_CTRL1, 32'h80);
      i_tio_pin_partner.set_count(1, 16'h0C0C);
      ce <= 1'b0;
      i_tio_pin_partner.set_pin(5, 1'b1);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      chk(irq, 1'b1);
      apb(1'b0, 8'h54, 32'h0);
      chk(rd, 32'h0000_0C0C);
      // reset in mid-run: function and start registers back to zero, mode to C0, pins undriven
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      chk(pin_oe_n, 32'hFF);
      chk(irq, 1'b0);
      chk(counter_run, 32'h0);
      apb(1'b0, tio_pkg::OFF_CTRL1, 32'h0);
      chk(rd, 32'h0);
      tally_and_finish();
   end
endmodule

`default_nettype wire
